// [hdl/nsf_map.svh]
// sentence framer constants: characters, codes, limits
`ifndef NSF_MAP_SVH
`define NSF_MAP_SVH
// ---------------------------------------------------------------
// framing and field characters
// ---------------------------------------------------------------
`define NSF_CH_START 8'h24
`define NSF_CH_COMMA 8'h2C
`define NSF_CH_STAR 8'h2A
`define NSF_CH_CR 8'h0D
`define NSF_CH_LF 8'h0A
`define NSF_CH_DOT 8'h2E
`define NSF_CH_MINUS 8'h2D
`define NSF_CH_SPACE 8'h20
`define NSF_CH_VALID 8'h41
`define NSF_CH_INVALID 8'h56
// ---------------------------------------------------------------
// talker codes, two characters, first in the high byte
// ---------------------------------------------------------------
`define NSF_TK_ALL 16'h474E
`define NSF_TK_GPS 16'h4750
`define NSF_TK_BDS 16'h4244
`define NSF_TK_GAL 16'h4741
`define NSF_TK_GLO 16'h474C
// ---------------------------------------------------------------
// length limits, counted without start marker and CR LF
// ---------------------------------------------------------------
`define NSF_MAX_SENT 7'h4F
`define NSF_MAX_BLK 7'h4A
`define NSF_TAIL_LEN 7'h03
`define NSF_BODY_CAP (`NSF_MAX_SENT - `NSF_TAIL_LEN)
// fixed degree/minute/second part of special fields
`define NSF_LAT_BASE 7'h04
`define NSF_LON_BASE 7'h05
`define NSF_TIME_BASE 7'h06
// reset value of the running checksum
`define NSF_CKS_RST 8'h00
`endif

// [hdl/nsf_pkg.sv]
// sentence framer types
package nsf_pkg;
  // operation presented on the user port
  typedef enum logic [1:0] {
    NSF_OP_START = 2'h0,
    NSF_OP_FIELD = 2'h1,
    NSF_OP_CHAR = 2'h2,
    NSF_OP_END = 2'h3
  } nsf_op_t;
  // source constellation
  typedef enum logic [2:0] {
    NSF_TS_GPS = 3'h0,
    NSF_TS_ALL = 3'h1,
    NSF_TS_BDS = 3'h2,
    NSF_TS_GAL = 3'h3,
    NSF_TS_GLO = 3'h4
  } nsf_talk_t;
  // field format classes
  typedef enum logic [3:0] {
    NSF_FT_STATUS = 4'h0,
    NSF_FT_LAT = 4'h1,
    NSF_FT_LON = 4'h2,
    NSF_FT_TIME = 4'h3,
    NSF_FT_VAR = 4'h4,
    NSF_FT_HEX = 4'h5,
    NSF_FT_ALPHA = 4'h6,
    NSF_FT_NUM = 4'h7,
    NSF_FT_TEXT = 4'h8
  } nsf_ftype_t;
  typedef enum logic [3:0] {
    NSF_ST_IDLE = 4'h1,
    NSF_ST_HEAD = 4'h2,
    NSF_ST_BODY = 4'h4,
    NSF_ST_TAIL = 4'h8
  } nsf_state_t;
  typedef struct packed {
    nsf_state_t st;
    logic [2:0] idx;
    logic [7:0] cks;
    logic [6:0] cnt;
    logic [6:0] blk;
    logic [6:0] fcnt;
    logic open;
    nsf_ftype_t ft;
    logic [6:0] flen;
    logic [15:0] talk;
    logic [23:0] typ;
    logic [7:0] tx_data;
    logic tx_valid;
    logic in_ready;
    logic busy;
    logic len_err;
    logic fmt_err;
  } nsf_reg_t;
endpackage : nsf_pkg

// [hdl/nsf_fldchk.sv]
// character and length checker for one data field
`timescale 1ns/1ps
`default_nettype none
`include "nsf_map.svh"
module nsf_fldchk
  import nsf_pkg::*;
(
  input var nsf_ftype_t ft, // format of the open field
  input wire logic [7:0] ch, // candidate character
  input wire logic [6:0] pos, // characters already in field
  input wire logic [6:0] flen, // fixed length for hex/alpha/num
  output logic char_ok, // character fits at this position
  output logic len_ok // field length is legal if closed now
);
  logic dig;
  logic hexd;
  logic alph;
  logic rsv;
  logic [6:0] base;
  // ---------------------------------------------------------------
  // character classes
  // ---------------------------------------------------------------
  always_comb begin
    dig = (ch >= 8'h30) && (ch <= 8'h39);
    hexd = dig || ((ch >= 8'h41) && (ch <= 8'h46));
    alph = ((ch >= 8'h41) && (ch <= 8'h5A)) ||
           ((ch >= 8'h61) && (ch <= 8'h7A));
    rsv = (ch == `NSF_CH_START) || (ch == `NSF_CH_STAR) ||
          (ch == `NSF_CH_COMMA);
    base = (ft == NSF_FT_LAT) ? `NSF_LAT_BASE :
           (ft == NSF_FT_LON) ? `NSF_LON_BASE : `NSF_TIME_BASE;
  end
  // ---------------------------------------------------------------
  // per-format check; an empty field is allowed in every named format, not in the default branch
  // ---------------------------------------------------------------
  always_comb begin
    char_ok = 1'b0;
    len_ok = (pos == 7'h00);
    unique case (ft)
      NSF_FT_STATUS: begin
        char_ok = (pos == 7'h00) &&
                  ((ch == `NSF_CH_VALID) || (ch == `NSF_CH_INVALID));
        len_ok = (pos <= 7'h01);
      end
      NSF_FT_LAT, NSF_FT_LON, NSF_FT_TIME: begin
        char_ok = (pos == base) ? (ch == `NSF_CH_DOT) : dig;
        len_ok = len_ok || (pos >= base);
      end
      NSF_FT_VAR: begin
        // any leading/trailing zero form passes unchanged
        char_ok = dig || (ch == `NSF_CH_DOT) || (ch == `NSF_CH_MINUS);
        len_ok = 1'b1;
      end
      NSF_FT_HEX: begin
        char_ok = hexd && (pos < flen);
        len_ok = len_ok || (pos == flen);
      end
      NSF_FT_ALPHA: begin
        char_ok = alph && (pos < flen);
        len_ok = len_ok || (pos == flen);
      end
      NSF_FT_NUM: begin
        char_ok = dig && (pos < flen);
        len_ok = len_ok || (pos == flen);
      end
      NSF_FT_TEXT: begin
        // only place a space may go
        char_ok = (ch >= `NSF_CH_SPACE) && (ch < 8'h7F) && !rsv;
        len_ok = 1'b1;
      end
      default: begin
        char_ok = 1'b0;
        len_ok = 1'b0;
      end
    endcase
  end
endmodule : nsf_fldchk
`default_nettype wire

// [hdl/nsf_framer.sv]
// sentence framer: builds one ASCII sentence from user operations
`timescale 1ns/1ps
`default_nettype none
`include "nsf_map.svh"
module nsf_framer
  import nsf_pkg::*;
(
  input wire logic mclk, // 100 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic op_valid, // user operation present
  input var nsf_op_t op_code, // start, field, char or end
  input var nsf_talk_t op_talk, // constellation, with start
  input wire logic [23:0] op_type, // sentence_type_code, with start
  input var nsf_ftype_t op_ftype, // data_field format, with field
  input wire logic [6:0] op_flen, // fixed length, with field
  input wire logic [7:0] op_data, // data_field character
  output logic op_ready, // operation taken when valid too
  output logic [7:0] tx_data, // character to transmitter
  output logic tx_valid, // character present
  input wire logic tx_ready, // transmitter takes character
  output logic busy, // sentence in progress
  output logic len_err, // a character was cut by a limit
  output logic fmt_err // a character or field broke format
);
  nsf_reg_t s_q;
  nsf_reg_t s_d;
  logic take;
  logic slot;
  logic room;
  logic char_ok;
  logic len_ok;
  logic em;
  logic [7:0] ec;
  logic [7:0] hc;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // nibble to upper-case ASCII hex
  function automatic logic [7:0] nsf_hex(input logic [3:0] n);
    nsf_hex = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : nsf_hex

  function automatic logic [15:0] nsf_code(input nsf_talk_t t);
    unique case (t)
      NSF_TS_ALL: nsf_code = `NSF_TK_ALL;
      NSF_TS_BDS: nsf_code = `NSF_TK_BDS;
      NSF_TS_GAL: nsf_code = `NSF_TK_GAL;
      NSF_TS_GLO: nsf_code = `NSF_TK_GLO;
      default: nsf_code = `NSF_TK_GPS;
    endcase
  endfunction : nsf_code

  nsf_fldchk u_chk (
    .ft(s_q.ft),
    .ch(op_data),
    .pos(s_q.fcnt),
    .flen(s_q.flen),
    .char_ok(char_ok),
    .len_ok(len_ok)
  );

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  // op_ready high implies tx slot empty, so a taken op can load
  always_comb begin
    s_d = s_q;
    em = 1'b0;
    ec = `NSF_CH_COMMA;
    hc = `NSF_CH_START;
    take = s_q.in_ready && op_valid;
    slot = !s_q.tx_valid || tx_ready;
    // both limits checked before each data-area character
    room = (s_q.blk < `NSF_MAX_BLK) && (s_q.cnt < `NSF_BODY_CAP);
    if (s_q.tx_valid && tx_ready) begin
      s_d.tx_valid = 1'b0;
    end
    unique case (s_q.st)
      NSF_ST_IDLE: begin
        if (take && (op_code == NSF_OP_START)) begin
          s_d.st = NSF_ST_HEAD;
          s_d.idx = 3'h0;
          s_d.cks = `NSF_CKS_RST;
          s_d.cnt = 7'h00;
          s_d.blk = 7'h00;
          s_d.fcnt = 7'h00;
          s_d.open = 1'b0;
          s_d.len_err = 1'b0;
          s_d.fmt_err = 1'b0;
          s_d.talk = nsf_code(op_talk);
          s_d.typ = op_type;
        end
      end
      NSF_ST_HEAD: begin
        unique case (s_q.idx)
          3'h0: hc = `NSF_CH_START;
          3'h1: hc = s_q.talk[15:8];
          3'h2: hc = s_q.talk[7:0];
          3'h3: hc = s_q.typ[23:16];
          3'h4: hc = s_q.typ[15:8];
          default: hc = s_q.typ[7:0];
        endcase
        if (slot) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = hc;
          // marker stays out of checksum and length
          if (s_q.idx != 3'h0) begin
            s_d.cks = s_q.cks ^ hc;
            s_d.cnt = s_q.cnt + 7'h01;
          end
          if (s_q.idx == 3'h5) begin
            s_d.st = NSF_ST_BODY;
          end else begin
            s_d.idx = s_q.idx + 3'h1;
          end
        end
      end
      NSF_ST_BODY: begin
        if (take) begin
          unique case (op_code)
            NSF_OP_FIELD: begin
              if (s_q.open && !len_ok) begin
                s_d.fmt_err = 1'b1;
              end
              s_d.open = 1'b1;
              s_d.ft = op_ftype;
              s_d.flen = op_flen;
              s_d.fcnt = 7'h00;
              em = room;
              ec = `NSF_CH_COMMA;
              if (!room) begin
                s_d.len_err = 1'b1;
              end
            end
            NSF_OP_CHAR: begin
              // a bad character is dropped, not sent
              if (!s_q.open || !char_ok) begin
                s_d.fmt_err = 1'b1;
              end else if (!room) begin
                s_d.len_err = 1'b1;
              end else begin
                em = 1'b1;
                ec = op_data;
                s_d.fcnt = s_q.fcnt + 7'h01;
              end
            end
            NSF_OP_END: begin
              if (s_q.open && !len_ok) begin
                s_d.fmt_err = 1'b1;
              end
              s_d.open = 1'b0;
              s_d.st = NSF_ST_TAIL;
              s_d.idx = 3'h0;
            end
            default: begin
              // a second start inside a sentence is ignored
              s_d.st = s_q.st;
            end
          endcase
        end
        if (em) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = ec;
          s_d.cks = s_q.cks ^ ec;
          s_d.cnt = s_q.cnt + 7'h01;
          s_d.blk = s_q.blk + 7'h01;
        end
      end
      NSF_ST_TAIL: begin
        unique case (s_q.idx)
          3'h0: hc = `NSF_CH_STAR;
          3'h1: hc = nsf_hex(s_q.cks[7:4]);
          3'h2: hc = nsf_hex(s_q.cks[3:0]);
          3'h3: hc = `NSF_CH_CR;
          default: hc = `NSF_CH_LF;
        endcase
        if (slot) begin
          s_d.tx_valid = 1'b1;
          s_d.tx_data = hc;
          if (s_q.idx < 3'h3) begin
            s_d.cnt = s_q.cnt + 7'h01;
          end
          if (s_q.idx == 3'h4) begin
            s_d.st = NSF_ST_IDLE;
          end else begin
            s_d.idx = s_q.idx + 3'h1;
          end
        end
      end
    endcase
    // registered ready keeps the user port free of combinational paths
    s_d.in_ready = ((s_d.st == NSF_ST_IDLE) || (s_d.st == NSF_ST_BODY))
                   && !s_d.tx_valid;
    s_d.busy = (s_d.st != NSF_ST_IDLE);
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= '{st: NSF_ST_IDLE, ft: NSF_FT_STATUS, cks: `NSF_CKS_RST,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // only driver of the serial character stream
  assign tx_data = s_q.tx_data;
  assign tx_valid = s_q.tx_valid;
  assign op_ready = s_q.in_ready;
  assign busy = s_q.busy;
  assign len_err = s_q.len_err;
  assign fmt_err = s_q.fmt_err;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  logic acc;
  logic [6:0] n_q;
  assign acc = tx_valid && tx_ready;
  // helper: characters accepted since the start marker
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      n_q <= 7'h00;
    end else if (acc) begin
      n_q <= (tx_data == `NSF_CH_START) ? 7'h01 : n_q + 7'h01;
    end
  end

  // helper: checksum of what the listener took, built apart from s_q.cks
  // so a slip in the datapath cannot hide inside its own check
  logic [7:0] x_q;
  logic in_q;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      x_q <= 8'h00;
      in_q <= 1'b0;
    end else if (acc) begin
      if (tx_data == `NSF_CH_START) begin
        x_q <= 8'h00;
        in_q <= 1'b1;
      end else if (tx_data == `NSF_CH_STAR) begin
        in_q <= 1'b0;
      end else if (in_q) begin
        x_q <= x_q ^ tx_data;
      end
    end
  end

  sequence seq_start;
    s_q.st == NSF_ST_IDLE && take && op_code == NSF_OP_START;
  endsequence
  sequence seq_star_taken;
    acc && tx_data == `NSF_CH_STAR;
  endsequence
  sequence seq_cks_hi;
    tx_valid && tx_data == nsf_hex(s_q.cks[7:4]);
  endsequence
  sequence seq_hi_taken;
    acc && s_q.st == NSF_ST_TAIL && s_q.idx == 3'h2;
  endsequence

  AST_START_MARK: assert property (
    seq_start |-> ##2 tx_valid && tx_data == `NSF_CH_START)
    else $error("sentence does not open with start marker");
  AST_TALKER: assert property (
    acc && n_q == 7'h01 |-> tx_data == s_q.talk[15:8])
    else $error("talker code not after start marker");
  AST_TYPE: assert property (
    acc && n_q == 7'h03 |-> tx_data == s_q.typ[23:16])
    else $error("type code not after talker code");
  AST_COMMA: assert property (
    s_q.st == NSF_ST_BODY && take && op_code == NSF_OP_FIELD && room
    |=> tx_valid && tx_data == `NSF_CH_COMMA)
    else $error("field not preceded by comma");
  AST_CKS: assert property (
    seq_star_taken |=> seq_cks_hi)
    else $error("checksum does not follow asterisk");
  AST_CRLF: assert property (
    acc && tx_data == `NSF_CH_CR |=> tx_valid && tx_data == `NSF_CH_LF)
    else $error("CR not followed by LF");
  AST_LEN79: assert property (
    s_q.cnt <= `NSF_MAX_SENT)
    else $error("sentence longer than limit");
  AST_BLK74: assert property (
    s_q.blk <= `NSF_MAX_BLK)
    else $error("data block longer than limit");
  AST_HOLD: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("character changed before transmitter took it");
  AST_SPACE: assert property (
    $rose(tx_valid) && tx_data == `NSF_CH_SPACE
    |-> s_q.st == NSF_ST_BODY && s_q.ft == NSF_FT_TEXT)
    else $error("space outside text field");
  // tail digits are held against the shadow sum, not the datapath sum
  AST_CKS_SUM: assert property (
    seq_star_taken |=> tx_valid && tx_data == nsf_hex(x_q[7:4]))
    else $error("checksum high digit differs from taken characters");
  AST_CKS_LO: assert property (
    seq_hi_taken |=> tx_valid && tx_data == nsf_hex(x_q[3:0]))
    else $error("checksum low digit differs from taken characters");
  AST_STATUS1: assert property (
    s_q.st == NSF_ST_BODY && take && op_code == NSF_OP_CHAR &&
    s_q.ft == NSF_FT_STATUS && s_q.fcnt != 7'h00 |=> !tx_valid)
    else $error("status field longer than one character");
  AST_ERR_CLR: assert property (
    seq_start |=> busy && !len_err && !fmt_err)
    else $error("new sentence did not clear its flags");
endmodule : nsf_framer
`default_nettype wire

// [verif/nsf_listener.sv]
// listener model on the far side of the framer's character port
`timescale 1ns/1ps
`default_nettype none
module nsf_listener (
  input wire logic mclk, // system clock
  input wire logic rst_b, // reset, active low
  input wire logic [7:0] tx_data, // character from framer
  input wire logic tx_valid, // character present
  output logic tx_ready, // character taken at this edge
  input wire logic slow, // stall on random cycles
  input wire logic [7:0] rnd, // random bits from the bench
  output logic [6:0] n_comma // commas seen in current sentence
);
  // ---------------------------------------------------------------
  // transmitter readiness
  // ---------------------------------------------------------------
  // only a ready line back; the listener never drives the data line
  assign tx_ready = !slow || rnd[0];
  // ---------------------------------------------------------------
  // field location
  // ---------------------------------------------------------------
  // fields vary in length, so they are found by counting commas
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      n_comma <= 7'h00;
    end else if (tx_valid && tx_ready) begin
      if (tx_data == 8'h24) begin
        n_comma <= 7'h00;
      end else if (tx_data == 8'h2C) begin
        n_comma <= n_comma + 7'h01;
      end
    end
  end
endmodule : nsf_listener
`default_nettype wire

// [verif/tb.sv]
// testbench: framer against a queue model of the sentence
`timescale 1ns/1ps
`default_nettype none
`include "nsf_map.svh"
`define TB_CHK(a, b) begin n_compared++; if ((a) !== (b)) begin \
  err_total++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module tb
  import nsf_pkg::*;
;
  // ---------------------------------------------------------------
  // signals and model state
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic op_valid = 1'b0;
  logic slow = 1'b0;
  nsf_op_t op_code = NSF_OP_START;
  nsf_talk_t op_talk = NSF_TS_GPS;
  logic [23:0] op_type = 24'h000000;
  nsf_ftype_t op_ftype = NSF_FT_STATUS;
  logic [6:0] op_flen = 7'h00;
  logic [7:0] op_data = 8'h00;
  logic [7:0] rnd = 8'h00;
  logic op_ready, tx_valid, tx_ready, busy, len_err, fmt_err;
  logic [7:0] tx_data;
  logic [6:0] n_comma;
  int err_total = 0;
  int n_compared = 0;
  int unsigned seed = 24727;
  logic [7:0] exp_q[$];
  logic [7:0] got_q[$];
  int ft, flen, len, blk, tno;
  bit open, efmt, elen;
  // unknown talker selection falls back to GP
  logic [15:0] tk [6] = '{`NSF_TK_GPS, `NSF_TK_ALL, `NSF_TK_BDS,
    `NSF_TK_GAL, `NSF_TK_GLO, `NSF_TK_GPS};
  string fs [10] = '{"A", "1234.56", "01234.5", "123456.70", "073.10",
    "1F", "aBc", "42", "a b", ""};
  int fts [10] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 4};

  nsf_framer nsf_framer_inst (.mclk(mclk), .rst_b(rst_b),
    .op_valid(op_valid), .op_code(op_code), .op_talk(op_talk),
    .op_type(op_type), .op_ftype(op_ftype), .op_flen(op_flen),
    .op_data(op_data), .op_ready(op_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .busy(busy),
    .len_err(len_err), .fmt_err(fmt_err));
  nsf_listener nsf_listener_inst (.mclk(mclk), .rst_b(rst_b),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .slow(slow), .rnd(rnd), .n_comma(n_comma));

  always #5 mclk = ~mclk;
  // random stall pattern changes away from the sampling edge
  always @(negedge mclk) rnd <= 8'(xs());
  // every character the listener takes
  always @(posedge mclk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) got_q.push_back(tx_data);
  end

  // ---------------------------------------------------------------
  // model functions
  // ---------------------------------------------------------------
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  // printable text character, never a framing character
  function automatic logic [7:0] rt();
    logic [7:0] c;
    c = 8'h20 + 8'(xs() % 95);
    return (c == "$" || c == "*" || c == ",") ? "x" : c;
  endfunction : rt
  function automatic bit fok(int f, int p, logic [7:0] c);
    bit d;
    d = c >= "0" && c <= "9";
    case (f)
      0: return p == 0 && (c == "A" || c == "V");
      1, 2, 3: return p == f + 3 ? c == "." : d;
      4: return d || c == "." || c == "-";
      5: return p < flen && (d || (c >= "A" && c <= "F"));
      6: return p < flen && ((c >= "A" && c <= "Z") ||
                             (c >= "a" && c <= "z"));
      7: return p < flen && d;
      default: return c >= " " && c <= "~" && c != "$" && c != "*" &&
                      c != ",";
    endcase
  endfunction : fok
  function automatic bit lok(int f, int n, int fl);
    case (f)
      0: return n <= 1;
      1, 2, 3: return n == 0 || n >= f + 3;
      5, 6, 7: return n == 0 || n == fl;
      default: return 1'b1;
    endcase
  endfunction : lok
  // head of five plus tail of three must stay within 79
  function automatic bit room();
    return blk < 74 && 5 + blk < 76;
  endfunction : room
  function automatic logic [7:0] hx(logic [3:0] v);
    return v < 10 ? 8'h30 + v : 8'h37 + v;
  endfunction : hx

  // ---------------------------------------------------------------
  // operation tasks
  // ---------------------------------------------------------------
  // caller has set the qualifiers at a falling edge already
  task automatic op(nsf_op_t c, logic [7:0] d);
    int k;
    op_valid = 1'b1;
    op_code = c;
    op_data = d;
    k = 0;
    while (op_ready !== 1'b1 && k < 500) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 500) err_total++;
    @(posedge mclk);
  endtask : op
  task automatic t_start(int t, logic [23:0] ty);
    @(negedge mclk);
    op_talk = nsf_talk_t'(t);
    op_type = ty;
    op(NSF_OP_START, 8'h00);
    exp_q = {8'h24, tk[t][15:8], tk[t][7:0], ty[23:16], ty[15:8], ty[7:0]};
    got_q = {};
    blk = 0;
    open = 1'b0;
    efmt = 1'b0;
    elen = 1'b0;
  endtask : t_start
  task automatic shut();
    if (open && !lok(ft, len, flen)) efmt = 1'b1;
  endtask : shut
  task automatic t_field(int f, int fl);
    shut();
    @(negedge mclk);
    op_ftype = nsf_ftype_t'(f);
    op_flen = 7'(fl);
    op(NSF_OP_FIELD, 8'h00);
    if (room()) begin
      exp_q.push_back(8'h2C);
      blk++;
    end else begin
      elen = 1'b1;
    end
    open = 1'b1;
    ft = f;
    flen = fl;
    len = 0;
  endtask : t_field
  task automatic t_char(logic [7:0] c);
    @(negedge mclk);
    op(NSF_OP_CHAR, c);
    if (!open || !fok(ft, len, c)) begin
      efmt = 1'b1;
    end else if (!room()) begin
      elen = 1'b1;
    end else begin
      exp_q.push_back(c);
      len++;
      blk++;
    end
  endtask : t_char
  task automatic t_str(string s);
    for (int i = 0; i < s.len(); i++) t_char(s[i]);
  endtask : t_str
  task automatic t_end();
    logic [7:0] x;
    int k, nc;
    shut();
    @(negedge mclk);
    op(NSF_OP_END, 8'h00);
    @(negedge mclk);
    op_valid = 1'b0;
    x = 8'h00;
    nc = 0;
    for (k = 1; k < exp_q.size(); k++) begin
      x ^= exp_q[k];
      nc += (exp_q[k] == 8'h2C);
    end
    exp_q = {exp_q, 8'h2A, hx(x[7:4]), hx(x[3:0]), 8'h0D, 8'h0A};
    k = 0;
    while (got_q.size() < exp_q.size() && k < 3000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 3000) err_total++;
    repeat (2) @(negedge mclk);
    `TB_CHK(got_q.size(), exp_q.size())
    for (k = 0; k < exp_q.size(); k++) `TB_CHK(got_q[k], exp_q[k])
    `TB_CHK(got_q[0], 8'h24)
    `TB_CHK(got_q[got_q.size() - 3], hx(x[3:0]))
    `TB_CHK(got_q[got_q.size() - 1], 8'h0A)
    `TB_CHK(n_comma, 7'(nc))
    `TB_CHK(fmt_err, efmt)
    `TB_CHK(len_err, elen)
    `TB_CHK(busy, 1'b0)
    tno++;
    $display("test %0d done, %0d characters", tno, got_q.size());
  endtask : t_end
  task automatic end_sim();
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_sim

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(negedge mclk);
    `TB_CHK(op_ready, 1'b0)
    `TB_CHK(tx_valid, 1'b0)
    rst_b = 1'b1;
    repeat (2) @(negedge mclk);
    `TB_CHK(op_ready, 1'b1)
    // every talker, every field class, odd passes with stalls
    for (int t = 0; t < 6; t++) begin
      slow = t[0];
      t_start(t, "GGA");
      for (int i = 0; i < 10; i++) begin
        t_field(fts[i], fs[i].len());
        t_str(fs[i]);
      end
      t_end();
    end
    // characters that break their field's format are dropped
    t_start(0, "TST");
    t_char("5");
    t_field(0, 1);
    t_str("XVA");
    t_field(7, 2);
    t_str("4A23");
    t_field(4, 0);
    t_str(" 5");
    t_end();
    // short fixed field is only flagged when it closes
    t_start(3, "HEX");
    t_field(5, 2);
    t_str("fE");
    t_field(6, 2);
    t_str("ab");
    t_end();
    // long random text is cut at the sentence cap
    t_start(1, "TXT");
    t_field(8, 0);
    repeat (80) t_char(rt());
    t_end();
    end_sim();
  end
  // hang guard, well beyond the expected run of a little over a thousand cycles
  initial begin
    #400000;
    err_total++;
    end_sim();
  end
endmodule : tb
`default_nettype wire
